// ### verilog/imb_top.sv
// Purpose: Interrupt mask register bank with latched requests, APB
// Assumes: Single 200 MHz core clock, async active-high reset
// Notes:   Reads take no wait state; read data comes from a flop loaded in setup
`timescale 1ns/1ps
module imb_top (
	input  wire logic                 core_clk_in,  // Core clock
	input  wire logic                 sys_rst_in,   // Async reset
	input  wire logic                 psel_in,      // APB select
	input  wire logic                 penable_in,   // APB enable
	input  wire logic                 pwrite_in,    // APB direction
	input  wire logic [11:0]          paddr_in,     // APB byte address
	input  wire logic [31:0]          pwdata_in,    // APB write data
	input  wire logic [3:0]           pstrb_in,     // APB byte strobes
	input  wire imb_pkg::imb_events_t events_in,    // Condition pulses
	output logic      [31:0]          prdata_out,   // APB read data
	output logic                      pready_out,   // APB ready
	output logic                      pslverr_out,  // APB error
	output logic                      irq_out,      // Interrupt lead
	output logic      [7:0]           pending_out   // Unmasked per bank
);
	import imb_pkg::*;

	// ==========================================================
	// Bus bundle
	// ==========================================================
	imb_apb_req_t apb; // Grouped view of the master's request

	assign apb.psel    = psel_in;
	assign apb.penable = penable_in;
	assign apb.pwrite  = pwrite_in;
	assign apb.paddr   = paddr_in;
	assign apb.pwdata  = pwdata_in;
	assign apb.pstrb   = pstrb_in;

	// ==========================================================
	// Event fan-in, one byte per bank
	// ==========================================================
	logic [7:0] ev [NUM_BANKS]; // Events indexed by bank

	// Bank 0: bit 7 all channels, 6-0 ch 25,21,17,13,9,5,1
	assign ev[0] = events_in.loopback_a;
	// Bank 1: bit 7 DS3, 6-0 ch 26,22,18,14,10,6,2
	assign ev[1] = events_in.loopback_b;
	// Bank 2: bit 7 new message, 6-0 ch 27..3
	assign ev[2] = events_in.far_end_alarm_lb;
	// Bank 3: bit 7 severe frame, 6-0 ch 28..4
	assign ev[3] = events_in.errored_frame_lb;
	// Bank 4: 7 signal loss, 6 frame loss, 4 idle
	assign ev[4] = events_in.ds3_rx_alarm;
	// Bank 5: 7 C-bit status, 6-0 tributaries 7..1
	assign ev[5] = events_in.cbit_ds2_frame;
	// Bank 6: counter saturation, FCS down to M-bit
	assign ev[6] = events_in.counter_sat;
	// Bank 7: rx status, rx FIFO, tx FIFO, tx status
	assign ev[7] = events_in.path_link;

	// ==========================================================
	// Address decode
	// ==========================================================
	logic [6:0] idx;        // Word index of the access
	logic       aligned;    // Low address bits are zero
	logic       in_range;   // Address fits in the index field
	logic       setup_ph;   // First cycle of a transfer
	logic       access_ph;  // Completing cycle of a transfer
	logic       lane0;      // Low byte strobed on a write
	logic [6:0] req_off;    // Offset into request window
	logic [6:0] mask_off;   // Offset into mask window
	logic [6:0] clr_off;    // Offset into clear window
	logic       hit_req;    // Request register addressed
	logic       hit_mask;   // Mask register addressed
	logic       hit_clr;    // Clear register addressed
	logic       mapped;     // Any register addressed
	logic       bad_dir;    // Write to request or read of clear

	assign idx       = apb.paddr[8:2];
	assign aligned   = (apb.paddr[1:0] == 2'h0);
	assign in_range  = (apb.paddr[11:9] == 3'h0);
	assign setup_ph  = apb.psel & ~apb.penable;
	assign access_ph = apb.psel & apb.penable;
	assign lane0     = apb.pstrb[0];
	assign req_off   = idx - IDX_REQ_BASE;
	assign mask_off  = idx - IDX_MASK_BASE;
	assign clr_off   = idx - IDX_CLR_BASE;

	// Windows are each eight words wide
	assign hit_req  = aligned & in_range & (req_off  < 7'(NUM_BANKS));
	assign hit_mask = aligned & in_range & (mask_off < 7'(NUM_BANKS));
	assign hit_clr  = aligned & in_range & (clr_off  < 7'(NUM_BANKS));
	assign mapped   = hit_req | hit_mask | hit_clr;

	// Requests are read-only and clears write-only
	assign bad_dir = (hit_req & apb.pwrite) | (hit_clr & ~apb.pwrite);

	// ==========================================================
	// Handshake
	// ==========================================================
	// No wait state on any access: read data settles in setup
	// and is presented from a flop during the access phase.
	assign pready_out  = access_ph;
	assign pslverr_out = access_ph & (~mapped | bad_dir);

	logic wr_ok; // Write commits this edge
	logic rd_ok; // Read completes this edge

	assign wr_ok = access_ph & apb.pwrite & ~pslverr_out;
	assign rd_ok = access_ph & ~apb.pwrite & ~pslverr_out;

	// ==========================================================
	// Mask registers and request banks
	// ==========================================================
	logic [7:0] mask  [NUM_BANKS]; // Mask register values
	logic [7:0] req   [NUM_BANKS]; // Latched request values
	logic [7:0] rdclr [NUM_BANKS]; // Read-clear per bank
	logic [7:0] wrclr [NUM_BANKS]; // Write-one-clear per bank
	logic [7:0] hit;               // Bank has an unmasked request
	logic [7:0] rd_snap;           // Request byte captured for read

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic sel_mask; // This bank's mask addressed
			logic sel_req;  // This bank's request addressed
			logic sel_clr;  // This bank's clear addressed

			assign sel_mask = hit_mask & (mask_off == 7'(b));
			assign sel_req  = hit_req  & (req_off  == 7'(b));
			assign sel_clr  = hit_clr  & (clr_off  == 7'(b));

			// Mask write, low byte only; starts at zero
			always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					mask[b] <= MASK_RESET;
				end else if (wr_ok & sel_mask & lane0) begin
					mask[b] <= apb.pwdata[7:0];
				end
			end

			// Only bits actually shown to software are cleared,
			// so an event after the snapshot stays pending.
			assign rdclr[b] = (rd_ok & sel_req) ? rd_snap : 8'h00;
			assign wrclr[b] = (wr_ok & sel_clr & lane0) ?
			                  apb.pwdata[7:0] : 8'h00;

			imb_req_bank u_bank (
				.core_clk_in (core_clk_in),
				.sys_rst_in  (sys_rst_in),
				.set_in      (ev[b]),
				.rd_clr_in   (rdclr[b]),
				.wr_clr_in   (wrclr[b]),
				.mask_in     (mask[b]),
				.req_out     (req[b]),
				.hit_out     (hit[b])
			);
		end
	endgenerate

	// ==========================================================
	// Named mask fields
	// ==========================================================
	// These views drive nothing on their own beyond the lead; they
	// document which source each bit gates and feed pending_out.
	logic       all_channel_loopback_mask;     // Bank 0 bit 7
	logic [6:0] channel_loopback_mask_n_a;     // Bank 0 bits 6-0
	logic       high_rate_loopback_mask;       // Bank 1 bit 7
	logic       new_far_end_message_mask;      // Bank 2 bit 7
	logic       severe_frame_error_mask;       // Bank 3 bit 7
	logic       line_signal_loss_mask;         // Bank 4 bit 7
	logic       cbit_status_mask;              // Bank 5 bit 7
	logic [6:0] tributary_frame_loss_mask;     // Bank 5 bits 6-0
	logic [2:0] rx_link_status_masks;          // Bank 7 bits 7-5
	logic [1:0] rx_link_fifo_masks;            // Bank 7 bits 4-3
	logic [1:0] tx_link_fifo_masks;            // Bank 7 bits 2-1
	logic       tx_link_status_mask;           // Bank 7 bit 0

	assign all_channel_loopback_mask = mask[0][BIT_TOP];
	assign channel_loopback_mask_n_a = mask[0][6:0];
	assign high_rate_loopback_mask   = mask[1][BIT_TOP];
	assign new_far_end_message_mask  = mask[2][BIT_TOP];
	assign severe_frame_error_mask   = mask[3][BIT_TOP];
	assign line_signal_loss_mask     = mask[4][BIT_TOP];
	assign cbit_status_mask          = mask[5][BIT_TOP];
	assign tributary_frame_loss_mask = mask[5][6:0];
	assign rx_link_status_masks      = mask[7][RX_STAT_HI:RX_STAT_LO];
	assign rx_link_fifo_masks        = mask[7][RX_FIFO_HI:RX_FIFO_LO];
	assign tx_link_fifo_masks        = mask[7][TX_FIFO_HI:TX_FIFO_LO];
	assign tx_link_status_mask       = mask[7][TX_STAT_BIT];

	// ==========================================================
	// Per-source gating of the multi-source banks
	// ==========================================================
	logic       g_loop_a;   // Bank 0 unmasked
	logic       g_loop_b;   // Bank 1 unmasked
	logic       g_new_msg;  // Bank 2 bit 7 unmasked
	logic       g_loop_c;   // Bank 2 bits 6-0 unmasked
	logic       g_sev;      // Bank 3 bit 7 unmasked
	logic       g_loop_d;   // Bank 3 bits 6-0 unmasked
	logic       g_alarm;    // Bank 4 unmasked
	logic       g_cbit;     // Bank 5 unmasked
	logic       g_sat;      // Bank 6 unmasked
	logic       g_rx_stat;  // Bank 7 bits 7-5 unmasked
	logic       g_rx_fifo;  // Bank 7 bits 4-3 unmasked
	logic       g_tx;       // Bank 7 bits 2-0 unmasked

	assign g_loop_a  = (req[0][BIT_TOP] & all_channel_loopback_mask)
	                 | |(req[0][6:0] & channel_loopback_mask_n_a);
	assign g_loop_b  = (req[1][BIT_TOP] & high_rate_loopback_mask)
	                 | |(req[1][6:0] & mask[1][6:0]);
	assign g_new_msg = req[2][BIT_TOP] & new_far_end_message_mask;
	assign g_loop_c  = |(req[2][6:0] & mask[2][6:0]);
	assign g_sev     = req[3][BIT_TOP] & severe_frame_error_mask;
	assign g_loop_d  = |(req[3][6:0] & mask[3][6:0]);
	assign g_alarm   = (req[4][BIT_TOP] & line_signal_loss_mask)
	                 | |(req[4][6:0] & mask[4][6:0]);
	assign g_cbit    = (req[5][BIT_TOP] & cbit_status_mask)
	                 | |(req[5][6:0] & tributary_frame_loss_mask);
	assign g_sat     = |(req[6] & mask[6]);
	assign g_rx_stat = |(req[7][RX_STAT_HI:RX_STAT_LO]
	                   & rx_link_status_masks);
	assign g_rx_fifo = |(req[7][RX_FIFO_HI:RX_FIFO_LO]
	                   & rx_link_fifo_masks);
	assign g_tx      = |(req[7][TX_FIFO_HI:TX_FIFO_LO] & tx_link_fifo_masks)
	                 | (req[7][TX_STAT_BIT] & tx_link_status_mask);

	// ==========================================================
	// Interrupt lead
	// ==========================================================
	logic [7:0] next_pending; // Per-bank unmasked summary

	assign next_pending = {g_rx_stat | g_rx_fifo | g_tx, g_sat, g_cbit,
	                       g_alarm, g_sev | g_loop_d, g_new_msg | g_loop_c,
	                       g_loop_b, g_loop_a};

	// Combinational lead: follows a mask write or a clear at once.
	// The bank-level hit is the same relation, ORed into the lead as well.
	assign irq_out = |next_pending | |hit;

	// Registered per-bank summary for status LEDs or polling
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pending_out <= REQ_RESET;
		end else begin
			pending_out <= next_pending;
		end
	end

	// ==========================================================
	// Read data
	// ==========================================================
	logic [7:0]  rd_byte;    // Selected register in setup
	logic [31:0] next_rdata; // Word to present next cycle

	assign rd_byte = hit_mask ? mask[mask_off[2:0]] :
	                 hit_req  ? req[req_off[2:0]]   : 8'h00;
	// Clear words and unmapped words read as zero
	assign next_rdata = {24'h00_0000, rd_byte};

	// Capture in setup, hold through the access phase
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prdata_out <= RDATA_RESET;
			rd_snap    <= REQ_RESET;
		end else if (setup_ph & ~apb.pwrite) begin
			prdata_out <= next_rdata;
			rd_snap    <= hit_req ? rd_byte : REQ_RESET;
		end
	end

endmodule

// ### verilog/imb_pkg.sv
// Purpose: Shared constants and types for the interrupt mask bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are byte address divided by four
package imb_pkg;

	// ==========================================================
	// Sizes
	// ==========================================================
	localparam int unsigned NUM_BANKS  = 8;  // Request/mask pairs
	localparam int unsigned BANK_W     = 8;  // Bits per register
	localparam int unsigned ADDR_W     = 12; // APB address width
	localparam int unsigned IDX_W      = 7;  // Register index width
	localparam int unsigned DATA_W     = 32; // APB data width

	// ==========================================================
	// Register indices (byte address = index * 4)
	// ==========================================================
	localparam logic [6:0] IDX_REQ_BASE  = 7'h25; // Request 25h..2ch
	localparam logic [6:0] IDX_MASK_BASE = 7'h2e; // Mask 2eh..35h
	localparam logic [6:0] IDX_CLR_BASE  = 7'h45; // W1C 45h..4ch

	// Mask register indices, one per bank
	localparam logic [6:0] IDX_LOOPBACK_MASK_A       = 7'h2e;
	localparam logic [6:0] IDX_LOOPBACK_MASK_B       = 7'h2f;
	localparam logic [6:0] IDX_FAR_END_ALARM_LB_MASK = 7'h30;
	localparam logic [6:0] IDX_ERRORED_FRAME_LB_MASK = 7'h31;
	localparam logic [6:0] IDX_DS3_RX_ALARM_MASK     = 7'h32;
	localparam logic [6:0] IDX_CBIT_DS2_FRAME_MASK   = 7'h33;
	localparam logic [6:0] IDX_COUNTER_SAT_MASK      = 7'h34;
	localparam logic [6:0] IDX_PATH_LINK_MASK        = 7'h35;

	// ==========================================================
	// Reset values and field positions
	// ==========================================================
	localparam logic [7:0]  MASK_RESET  = 8'h00; // All sources off
	localparam logic [7:0]  REQ_RESET   = 8'h00; // Nothing pending
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam int unsigned BIT_TOP     = 7;     // Single-source bit
	localparam int unsigned RX_STAT_HI  = 7;     // Rx link status 7-5
	localparam int unsigned RX_STAT_LO  = 5;
	localparam int unsigned RX_FIFO_HI  = 4;     // Rx link FIFO 4-3
	localparam int unsigned RX_FIFO_LO  = 3;
	localparam int unsigned TX_FIFO_HI  = 2;     // Tx link FIFO 2-1
	localparam int unsigned TX_FIFO_LO  = 1;
	localparam int unsigned TX_STAT_BIT = 0;     // Tx link status

	// ==========================================================
	// Event carrier: one byte of condition pulses per bank
	// ==========================================================
	typedef struct packed {
		logic [7:0] path_link;        // Bank 7, request 2ch
		logic [7:0] counter_sat;      // Bank 6, request 2bh
		logic [7:0] cbit_ds2_frame;   // Bank 5, request 2ah
		logic [7:0] ds3_rx_alarm;     // Bank 4, request 29h
		logic [7:0] errored_frame_lb; // Bank 3, request 28h
		logic [7:0] far_end_alarm_lb; // Bank 2, request 27h
		logic [7:0] loopback_b;       // Bank 1, request 26h
		logic [7:0] loopback_a;       // Bank 0, request 25h
	} imb_events_t;

	// APB request bundle from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [3:0]        pstrb;
	} imb_apb_req_t;

endpackage

// ### verilog/imb_req_bank.sv
// Purpose: One 8-bit latched request register with masked output
// Assumes: Events are one-cycle or level conditions on core clock
// Notes:   A set in the same cycle as a clear always wins
`timescale 1ns/1ps
module imb_req_bank (
	input  wire logic       core_clk_in,  // Core clock
	input  wire logic       sys_rst_in,   // Async reset, high
	input  wire logic [7:0] set_in,       // Condition occurred
	input  wire logic [7:0] rd_clr_in,    // Clear on read, bitwise
	input  wire logic [7:0] wr_clr_in,    // Write-one clear
	input  wire logic [7:0] mask_in,      // Mask register value
	output logic      [7:0] req_out,      // Latched requests
	output logic            hit_out       // Any unmasked request
);
	import imb_pkg::*;

	// ==========================================================
	// Next state
	// ==========================================================
	logic [7:0] next_req; // Request value after this edge
	logic [7:0] clr_any;  // Either clear source

	assign clr_any  = rd_clr_in | wr_clr_in;
	// Set beats clear so no event slips through a read
	assign next_req = (req_out & ~clr_any) | set_in;

	// Latch requests
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			req_out <= REQ_RESET;
		end else begin
			req_out <= next_req;
		end
	end

	// Bit-for-bit gate onto the shared lead
	assign hit_out = |(req_out & mask_in);

endmodule

// ### tb/imb_monitor.sv
// Purpose: Port-level assertions for the interrupt mask bank
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Attached to imb_top by the bind below the module
`timescale 1ns/1ps
module imb_monitor (
	input wire logic                 core_clk_in,
	input wire logic                 sys_rst_in,
	input wire logic                 psel_in,
	input wire logic                 penable_in,
	input wire logic                 pwrite_in,
	input wire logic [11:0]          paddr_in,
	input wire logic [31:0]          pwdata_in,
	input wire logic [3:0]           pstrb_in,
	input wire imb_pkg::imb_events_t events_in,
	input wire logic [31:0]          prdata_out,
	input wire logic                 pready_out,
	input wire logic                 pslverr_out,
	input wire logic                 irq_out,
	input wire logic [7:0]           pending_out
);
	import imb_pkg::*;
	// ==========================================================
	// Address decode helpers
	// ==========================================================
	wire [6:0] idx     = paddr_in[8:2]; // Register index
	wire       aligned = (paddr_in[1:0] == 2'h0) && (paddr_in[11:9] == 3'h0);
	wire       is_mask = aligned && (idx >= 7'h2e) && (idx <= 7'h35); // Mask bank
	wire       is_req  = aligned && (idx >= 7'h25) && (idx <= 7'h2c); // Request bank
	wire       is_rsvd = aligned && ((idx == 7'h2d) || (idx == 7'h36)); // Holes in the map
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ==========================================================
	// Bus phases
	// ==========================================================
	sequence s_acc;
		psel_in && penable_in;
	endsequence
	sequence s_rset;
		psel_in && !penable_in && !pwrite_in;
	endsequence
	// ==========================================================
	// Properties
	// ==========================================================
	// Pending summary lags the lead by exactly one cycle
	property p_pend; (pending_out != 8'h00) == $past(irq_out); endproperty
	// Only a bus access can take the lead down
	property p_fall; $fell(irq_out) |-> $past(psel_in && penable_in); endproperty
	// Lead rises only after an event or a mask write
	property p_rise; $rose(irq_out) |-> $past(events_in != 64'h0) || $past(psel_in && penable_in && pwrite_in);
	endproperty
	property p_mask_ok; s_acc ##0 is_mask |-> !pslverr_out && pready_out; endproperty
	property p_req_ro; s_acc ##0 (pwrite_in && is_req) |-> pslverr_out; endproperty
	property p_rsvd; s_acc ##0 (is_rsvd || !aligned) |-> pslverr_out; endproperty
	// Read data taken in the access still stands one edge later, upper bits zero
	property p_rd_acc; s_rset ##1 s_acc |=> $stable(prdata_out) && (prdata_out[31:8] == 24'h0); endproperty
	property p_rd_hold; !$past(psel_in && !penable_in && !pwrite_in) |-> $stable(prdata_out); endproperty
	a_pend: assert property (p_pend) else $error("pending does not follow lead");
	a_fall: assert property (p_fall) else $error("lead fell without access");
	a_rise: assert property (p_rise) else $error("lead rose without cause");
	a_mask_ok: assert property (p_mask_ok) else $error("mask access refused");
	a_req_ro: assert property (p_req_ro) else $error("request write accepted");
	a_rsvd: assert property (p_rsvd) else $error("reserved access accepted");
	a_rd_acc: assert property (p_rd_acc) else $error("read data moved in access");
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed unasked");
endmodule
bind imb_top imb_monitor u_mon (
	.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
	.events_in(events_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .irq_out(irq_out), .pending_out(pending_out)
);

// ### tb/imb_irq_host.sv
// Purpose: Processor-side model that watches the interrupt lead
// Assumes: Lead is a level, high while an enabled request is latched
// Notes:   Sticky flag stands for the handler having been entered
`timescale 1ns/1ps
module imb_irq_host (
	input  wire logic core_clk_in, // Core clock
	input  wire logic sys_rst_in,  // Async reset
	input  wire logic irq_in,      // Interrupt lead
	input  wire logic ack_in,      // Handler done
	output logic      seen_out     // Lead seen since last ack
);
	// Ack wins so a still-high lead re-arms only on the next cycle
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) seen_out <= 1'b0;
		else if (ack_in) seen_out <= 1'b0;
		else if (irq_in) seen_out <= 1'b1;
	end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the interrupt mask bank
// Assumes: Bench is the APB master; host model watches the lead
// Notes:   One task per scenario; events are one-cycle pulses
`timescale 1ns/1ps
module tb;
	import imb_pkg::*;
	// ==========================================================
	// Signals
	// ==========================================================
	logic        core_clk_in;
	logic        sys_rst_in;
	logic        psel, penable, pwrite, pready, pslverr, irq, ack, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [7:0]  pending;
	imb_events_t events;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cycles = 0;
	imb_top dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .events_in(events),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .pending_out(pending));
	imb_irq_host u_host (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .irq_in(irq), .ack_in(ack),
		.seen_out(seen));
	// ==========================================================
	// Clock, timeout, verdict
	// ==========================================================
	initial core_clk_in = 1'b0;
	always #2.5 core_clk_in = ~core_clk_in;
	// Whole run needs under 2000 cycles; this cuts a hang
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
		n_tests++;
		if (seen_v !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen_v);
		end
	endtask
	// ==========================================================
	// Bus and event drivers
	// ==========================================================
	// Request held until pready is sampled high; no latency assumed
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd_v, output logic err);
		@(posedge core_clk_in);
		{psel, penable, pwrite} <= {2'h2, wr};
		{paddr, pwdata} <= {a, wd};
		@(posedge core_clk_in);
		penable <= 1'b1;
		// No limit here; only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		rd_v = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
		#1;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, {3'h0, idx, 2'h0}, {24'h0, d}, r, e);
		check("write error flag", e, 1'b0);
	endtask
	task automatic rd(input logic [6:0] idx, input logic [7:0] exp, input string what);
		logic [31:0] r;
		logic e;
		apb(1'b0, {3'h0, idx, 2'h0}, 32'h0, r, e);
		check(what, r, {24'h0, exp});
	endtask
	// One-cycle condition on one bank; lead is settled on return
	task automatic pulse(input int bank, input logic [7:0] bits);
		logic [63:0] ev;
		ev = 64'h0;
		ev[bank*8 +: 8] = bits;
		@(posedge core_clk_in);
		events <= imb_events_t'(ev);
		@(posedge core_clk_in);
		events <= '0;
		#1;
	endtask
	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic test_reset();
		check("lead after reset", irq, 1'b0);
		for (int n = 0; n < 8; n++) rd(IDX_MASK_BASE + 7'(n), 8'h00, "mask reset value");
		$display("test_reset done");
	endtask
	// Walk one enabled bit through every bank, others raised but masked
	task automatic test_gate();
		logic [7:0] b;
		for (int n = 0; n < 8; n++) begin
			for (int k = 0; k < 8; k++) begin
				b = 8'h01 << k;
				wr(IDX_MASK_BASE + 7'(n), b);
				pulse(n, ~b);
				check("lead with masked bits", irq, 1'b0);
				rd(IDX_REQ_BASE + 7'(n), ~b, "latched requests");
				pulse(n, b);
				check("lead from enabled bit", irq, 1'b1);
				@(posedge core_clk_in);
				#1;
				check("pending bank", pending, 8'h01 << n);
				check("host saw lead", seen, 1'b1);
				rd(IDX_MASK_BASE + 7'(n), b, "mask readback");
				rd(IDX_REQ_BASE + 7'(n), b, "request before clear");
				check("lead after request read", irq, 1'b0);
				rd(IDX_REQ_BASE + 7'(n), 8'h00, "request after clear");
				@(posedge core_clk_in);
				ack <= 1'b1;
				@(posedge core_clk_in);
				ack <= 1'b0;
			end
			wr(IDX_MASK_BASE + 7'(n), 8'h00);
		end
		$display("test_gate done");
	endtask
	// Reserved, unaligned, out of range, read-only and write-only places
	task automatic test_errors();
		logic [12:0] bad [6] = '{13'h00b4, 13'h00d8, 13'h10b9, 13'h12b8, 13'h1094, 13'h0114};
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 6; i++) begin
			apb(bad[i][12], bad[i][11:0], 32'hff, r, e);
			check("refused access", e, 1'b1);
		end
		// Write with the low byte lane off must leave the mask alone
		@(posedge core_clk_in);
		pstrb <= 4'he;
		wr(IDX_MASK_BASE, 8'hff);
		@(posedge core_clk_in);
		pstrb <= 4'hf;
		rd(IDX_MASK_BASE, 8'h00, "mask after refused write");
		$display("test_errors done");
	endtask
	// Raise, mask partly, clear by write-one, then check what remains
	task automatic test_clear();
		wr(IDX_MASK_BASE + 7'd4, 8'hff);
		pulse(4, 8'h81);
		check("lead raised", irq, 1'b1);
		wr(IDX_MASK_BASE + 7'd4, 8'h01);
		check("lead partly masked", irq, 1'b1);
		wr(IDX_CLR_BASE + 7'd4, 8'h01);
		check("lead after clear", irq, 1'b0);
		rd(IDX_REQ_BASE + 7'd4, 8'h80, "request left after clear");
		wr(IDX_MASK_BASE + 7'd4, 8'h00);
		$display("test_clear done");
	endtask
	// Reset in mid-run must drop the lead and every mask
	task automatic test_midreset();
		wr(IDX_MASK_BASE + 7'd7, 8'h01);
		pulse(7, 8'h01);
		check("lead before reset", irq, 1'b1);
		@(posedge core_clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		#1;
		test_reset();
		pulse(7, 8'h01);
		check("lead with masks reset", irq, 1'b0);
		$display("test_midreset done");
	endtask
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{psel, penable, pwrite} = 3'h0;
		{paddr, pwdata} = 44'h0;
		pstrb = 4'hf;
		events = '0;
		ack = 1'b0;
		sys_rst_in = 1'b1;
		repeat (3) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		#1;
		test_reset();
		test_gate();
		test_errors();
		test_clear();
		test_midreset();
		summarize();
	end
endmodule
